// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        psel   = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, prev, fire = 1'b0;
  logic        out0, out1, m0, m1, ovf, irq, cap0, cap1;
  int          num_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          base = 0;
  int          c, i, k, hi, mc, co, m0c;
  int          t0[$];
  int          t1[$];
  int          pw[3] = '{0, 2, 5};
  int          eh[3] = '{0, 4, 10};
  int          em[3] = '{2, 2, 0};
  int          ec[3] = '{0, 2, 0};

  // Clock, 100 ns period
  always #50 mclk_i = ~mclk_i;

  tpw_timer DUT (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .capture_in_0_i(cap0), .capture_in_1_i(cap1),
    .timer_out_0_o(out0), .timer_out_1_o(out1), .match0_irq_o(m0),
    .match1_irq_o(m1), .overflow_irq_o(ovf), .irq_o(irq));

  tpw_pin_model #(.PULSE_LEN(4)) PINS (.mclk_i(mclk_i), .fire_i(fire),
    .cap0_o(cap0), .cap1_o(cap1));

  // Cycle stamp of each channel pulse, relative to base, set only at the first free-running start
  always @(posedge mclk_i) begin
    #1;
    cyc++;
    if (m0 === 1'b1) t0.push_back(cyc - base);
    if (m1 === 1'b1) t1.push_back(cyc - base);
  end

  // Compare one value
  task check(input string nm, input logic [31:0] exp,
             input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : check

  // One APB transfer; result left in rd and err
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Report counts and end the run
  task print_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    repeat (95000) @(posedge mclk_i);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Reset values and an unmapped address
    apb(0, tpw_pkg::OFS_CCR0, 0);
    check("ccr0 reset", 0, rd);
    apb(0, tpw_pkg::OFS_MASK, 0);
    check("mask reset", 0, rd);
    apb(0, 8'h40, 0);
    check("unmapped slverr", 1, err);
    check("unmapped data", 0, rd);
    check("pready", 1, pready);
    // Free-run compare with interval reload of 8 counts
    apb(1, tpw_pkg::OFS_CCR0, 7);
    apb(1, tpw_pkg::OFS_CCR1, 9);
    apb(1, tpw_pkg::OFS_MASK, 32'h4);
    apb(1, tpw_pkg::OFS_CTL1, 32'h5);
    apb(1, tpw_pkg::OFS_CTL0, 32'h80);
    base = cyc + 1;
    repeat (2) @(posedge mclk_i);
    #1;
    check("start out0", 1, out0);
    check("start out1", 1, out1);
    for (i = 0; i < 20 && t0.size() == 0; i++) @(posedge mclk_i);
    apb(1, tpw_pkg::OFS_CCR0, 15);
    repeat (8) @(posedge mclk_i);
    #1;
    check("m0 first", 8, t0[0]);
    check("m0 reload", 16, t0[1]);
    check("m0 count", 2, t0.size());
    check("m1 time", 10, t1[0]);
    check("out0 toggles", 1, out0);
    check("out1 toggle", 0, out1);
    // Interrupt masking and clear on read
    check("irq masked", 0, irq);
    apb(1, tpw_pkg::OFS_MASK, 32'h3);
    #1;
    check("irq unmasked", 1, irq);
    apb(0, tpw_pkg::OFS_STAT, 0);
    check("status", 32'h3, rd);
    #1;
    check("irq cleared", 0, irq);
    // Counter read tracks the running count
    apb(0, tpw_pkg::OFS_CNT, 0);
    c = rd;
    apb(0, tpw_pkg::OFS_CNT, 0);
    check("counter step", c + 3, rd);
    // Overflow pulse, sticky flag and its clear
    for (i = 0; i < 70000 && ovf !== 1'b1; i++) begin
      @(posedge mclk_i);
      #1;
    end
    check("overflow pulse", 1, ovf);
    apb(0, tpw_pkg::OFS_OPT0, 0);
    check("overflow flag", 1, rd[0]);
    repeat (5) @(posedge mclk_i);
    apb(1, tpw_pkg::OFS_OPT0, 32'h1);
    apb(0, tpw_pkg::OFS_OPT0, 0);
    check("flag kept", 1, rd[0]);
    apb(1, tpw_pkg::OFS_OPT0, 32'h0);
    apb(0, tpw_pkg::OFS_OPT0, 0);
    check("flag cleared", 0, rd[0]);
    // Capture: channel 0 on rising, channel 1 on falling edge
    apb(1, tpw_pkg::OFS_CTL0, 0);
    apb(1, tpw_pkg::OFS_OPT0, 32'h30);
    apb(1, tpw_pkg::OFS_IOC, 32'h9);
    apb(1, tpw_pkg::OFS_CTL0, 32'h80);
    t0.delete();
    t1.delete();
    @(posedge mclk_i);
    fire <= 1'b1;
    @(posedge mclk_i);
    fire <= 1'b0;
    repeat (20) @(posedge mclk_i);
    check("capture0 count", 1, t0.size());
    check("capture1 count", 1, t1.size());
    apb(0, tpw_pkg::OFS_CCR0, 0);
    c = rd;
    apb(0, tpw_pkg::OFS_CCR1, 0);
    check("capture gap", c + 4, rd);
    // PWM at 0%, 40% and 100% duty, period 5
    apb(1, tpw_pkg::OFS_CTL0, 0);
    apb(1, tpw_pkg::OFS_CTL1, 32'h4);
    apb(1, tpw_pkg::OFS_CCR0, 4);
    for (k = 0; k < 3; k++) begin
      apb(1, tpw_pkg::OFS_CCR1, pw[k]);
      apb(1, tpw_pkg::OFS_CTL0, 32'h80);
      repeat (3) @(posedge mclk_i);
      #1;
      prev = out1;
      hi = 0;
      mc = 0;
      co = 0;
      m0c = 0;
      repeat (10) begin
        @(posedge mclk_i);
        #1;
        hi += (out1 === 1'b1);
        m0c += (m0 === 1'b1);
        mc += (m1 === 1'b1);
        if (m1 === 1'b1 && prev === 1'b1 && out1 === 1'b0) co++;
        prev = out1;
      end
      check("pwm high cycles", eh[k], hi);
      check("pwm m1 pulses", em[k], mc);
      check("pwm m1 at edge", ec[k], co);
      check("pwm m0 pulses", 2, m0c);
      apb(1, tpw_pkg::OFS_CTL0, 0);
    end
    print_verdict();
  end
endmodule : testbench

// ==== bench/tpw_pin_model.sv ====
`timescale 1ns/1ps
// Drives one clean pulse on both capture pins at each request
module tpw_pin_model #(
  parameter int PULSE_LEN = 4
) (
  input  wire logic mclk_i,
  input  wire logic fire_i,
  output logic      cap0_o,
  output logic      cap1_o
);
  int left_q = 0;

  // Pulse length counter; pins rest low between pulses
  always @(posedge mclk_i) begin
    if (fire_i) begin
      left_q <= PULSE_LEN;
    end else if (left_q > 0) begin
      left_q <= left_q - 1;
    end
  end

  // Rising edge then falling edge, PULSE_LEN cycles apart
  assign cap0_o = (left_q > 0);
  assign cap1_o = (left_q > 0);
endmodule : tpw_pin_model

// ==== hw/tpw_pkg.sv ====
package tpw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTL0 = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_OPT0 = 8'h08;
  localparam logic [7:0] OFS_IOC  = 8'h0C;
  localparam logic [7:0] OFS_CCR0 = 8'h10;
  localparam logic [7:0] OFS_CCR1 = 8'h14;
  localparam logic [7:0] OFS_CNT  = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_MASK = 8'h20;

  // Field positions
  localparam int CE_POS   = 7;
  localparam int OVF_POS  = 0;
  localparam int ROLE_LSB = 4;

  // Mode codes and capture edge bits
  localparam logic [2:0] MODE_PWM  = 3'h4;
  localparam logic [2:0] MODE_FREE = 3'h5;
  localparam int EDGE_RISE = 0;
  localparam int EDGE_FALL = 1;

  // Counter limits
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

  // Reset values
  localparam logic       RST_CE   = 1'h0;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [1:0] RST_ROLE = 2'h0;
  localparam logic [3:0] RST_EDGE = 4'h0;
  localparam logic [15:0] RST_CCR = 16'h0000;
  localparam logic [2:0] RST_MASK = 3'h0;

  // Interrupt events, also the status and mask layout
  typedef struct packed {
    logic ovf;
    logic m1;
    logic m0;
  } tpw_evt_t;

  // Run state of the channel
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PWM  = 3'b010,
    ST_FREE = 3'b100
  } tpw_state_t;
endpackage : tpw_pkg

// ==== hw/tpw_timer.sv ====
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
// Operation
// - Mode field value 100 selects PWM output operation.
// - PWM period is compare 0 plus one clocks, width compare 1 clocks.
// - Compare 1 of zero keeps PWM output always inactive.
// - Compare 1 zero still gives one compare-1 interrupt every period.
// - Compare 1 equal to compare 0 plus one keeps output always active.
// - Compare 0 at FFFFH makes full duty impossible.
// - Outside PWM, compare-1 interrupt comes one count after the equality.
// - In PWM, compare-1 interrupt comes with the output edge, one earlier.
// - Mode 101 selects free-running; counting starts on count enable set.
// - Each capture/compare register has its own role select bit.
// - Free-running start inverts both timer outputs.
// - Compare value D gives interrupt and output toggle at count D plus one.
// - After FFFFH the counter wraps, raising overflow interrupt and flag.
// - Overflow flag stays set until software clears it by a write.
// - Free-running compare uses a rewritten value at once, unbuffered.
// - Capture edge stores the counter and raises the channel interrupt.
// - Counter read register returns the present counter value.
module tpw_timer (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        capture_in_0_i,
  input  wire logic        capture_in_1_i,
  output logic             timer_out_0_o,
  output logic             timer_out_1_o,
  output logic             match0_irq_o,
  output logic             match1_irq_o,
  output logic             overflow_irq_o,
  output logic             irq_o
);
  logic                 ce_q;
  logic [2:0]           mode_q;
  logic [1:0]           role_q;
  logic [3:0]           edge_q;
  logic                 ovf_q;
  logic [2:0]           mask_q;
  logic [15:0]          ccr_q [2];
  logic [15:0]          buf_q [2];
  logic [15:0]          beff  [2];
  logic                 pend_q;
  logic [15:0]          cnt_q;
  logic [15:0]          cnt_d;
  tpw_pkg::tpw_state_t  st_q;
  tpw_pkg::tpw_evt_t    ev_d;
  tpw_pkg::tpw_evt_t    ev_q;
  tpw_pkg::tpw_evt_t    stat_q;
  logic [2:0]           clr;
  logic [1:0]           out_q;
  logic [31:0]          prdata_q;
  logic [1:0]           cap_pin;
  logic [1:0]           cmp;
  logic [1:0]           cap;
  logic                 wr_en;
  logic                 rd_acc;
  logic                 rd_set;
  logic                 start;
  logic                 stop;
  logic                 start_pwm;
  logic                 start_fr;
  logic                 pwm;
  logic                 fr;
  logic                 pwm_act;
  logic                 wrap_pwm;
  logic                 ld_buf;

  // Write strobe for one register
  function automatic logic wsel(input logic [7:0] ofs);
    return wr_en && (paddr_i == ofs);
  endfunction : wsel

  // Mapped address check
  function automatic logic hit(input logic [7:0] a);
    case (a)
      tpw_pkg::OFS_CTL0, tpw_pkg::OFS_CTL1, tpw_pkg::OFS_OPT0,
      tpw_pkg::OFS_IOC, tpw_pkg::OFS_CCR0, tpw_pkg::OFS_CCR1,
      tpw_pkg::OFS_CNT, tpw_pkg::OFS_STAT, tpw_pkg::OFS_MASK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : hit

  // Bus phase decode
  assign wr_en     = psel_i & penable_i & pwrite_i;
  assign rd_acc    = psel_i & penable_i & ~pwrite_i;
  assign rd_set    = psel_i & ~penable_i & ~pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit(paddr_i);
  assign prdata_o  = prdata_q;

  // Start and stop of counting
  assign start     = wsel(tpw_pkg::OFS_CTL0) & pwdata_i[tpw_pkg::CE_POS]
                     & ~ce_q;
  assign stop      = wsel(tpw_pkg::OFS_CTL0) & ~pwdata_i[tpw_pkg::CE_POS];
  assign start_pwm = start & (mode_q == tpw_pkg::MODE_PWM);
  assign start_fr  = start & (mode_q == tpw_pkg::MODE_FREE);
  assign pwm       = (st_q == tpw_pkg::ST_PWM);
  assign fr        = (st_q == tpw_pkg::ST_FREE);
  assign pwm_act   = (pwm & ~stop) | start_pwm;
  assign wrap_pwm  = pwm & (cnt_q == buf_q[0]);
  assign ld_buf    = start_pwm | (wrap_pwm & pend_q);

  // Control registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ce_q   <= tpw_pkg::RST_CE;
      mode_q <= tpw_pkg::RST_MODE;
      role_q <= tpw_pkg::RST_ROLE;
      edge_q <= tpw_pkg::RST_EDGE;
      mask_q <= tpw_pkg::RST_MASK;
    end else begin
      if (wsel(tpw_pkg::OFS_CTL0)) ce_q <= pwdata_i[tpw_pkg::CE_POS];
      if (wsel(tpw_pkg::OFS_CTL1)) mode_q <= pwdata_i[2:0];
      if (wsel(tpw_pkg::OFS_OPT0)) begin
        role_q <= pwdata_i[tpw_pkg::ROLE_LSB +: 2];
      end
      if (wsel(tpw_pkg::OFS_IOC)) edge_q <= pwdata_i[3:0];
      if (wsel(tpw_pkg::OFS_MASK)) mask_q <= pwdata_i[2:0];
    end
  end

  // Run state, locked at start
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= tpw_pkg::ST_IDLE;
    end else if (stop) begin
      st_q <= tpw_pkg::ST_IDLE;
    end else if (start) begin
      case (mode_q)
        tpw_pkg::MODE_PWM:  st_q <= tpw_pkg::ST_PWM;
        tpw_pkg::MODE_FREE: st_q <= tpw_pkg::ST_FREE;
        default:            st_q <= tpw_pkg::ST_IDLE;
      endcase
    end
  end

  // Per channel capture path, compare match and registers
  assign cap_pin = {capture_in_1_i, capture_in_0_i};
  for (genvar i = 0; i < 2; i++) begin : g_ch
    localparam logic [7:0] OFS = (i == 0) ? tpw_pkg::OFS_CCR0
                                          : tpw_pkg::OFS_CCR1;
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic det;

    // Two-stage synchroniser and previous level
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
      end else begin
        s1_q <= cap_pin[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end

    // Valid edge detection
    assign det = (edge_q[2*i + tpw_pkg::EDGE_RISE] & s2_q & ~s3_q)
               | (edge_q[2*i + tpw_pkg::EDGE_FALL] & ~s2_q & s3_q);
    assign cmp[i] = fr & ~role_q[i] & (cnt_q == ccr_q[i]);
    assign cap[i] = fr & role_q[i] & det;

    // Capture wins over a software write
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        ccr_q[i] <= tpw_pkg::RST_CCR;
      end else if (cap[i]) begin
        ccr_q[i] <= cnt_q;
      end else if (wsel(OFS)) begin
        ccr_q[i] <= pwdata_i[15:0];
      end
    end

    // PWM buffer, reloaded at start or at a period end armed by a compare 1 write
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        buf_q[i] <= tpw_pkg::RST_CCR;
      end else if (ld_buf) begin
        buf_q[i] <= ccr_q[i];
      end
    end
    assign beff[i] = ld_buf ? ccr_q[i] : buf_q[i];
  end

  // Buffer transfer armed by a compare 1 write
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else if (wsel(tpw_pkg::OFS_CCR1)) begin
      pend_q <= 1'b1;
    end else if (ld_buf | stop) begin
      pend_q <= 1'b0;
    end
  end

  // Next counter value
  always_comb begin
    cnt_d = tpw_pkg::CNT_ZERO;
    if (start | stop) begin
      cnt_d = tpw_pkg::CNT_ZERO;
    end else if (pwm) begin
      cnt_d = wrap_pwm ? tpw_pkg::CNT_ZERO
                       : cnt_q + tpw_pkg::CNT_ONE;
    end else if (fr) begin
      cnt_d = cnt_q + tpw_pkg::CNT_ONE;
    end
  end

  // Counter
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= tpw_pkg::CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Events for the next cycle
  always_comb begin
    ev_d.ovf = fr & ~stop & (cnt_q == tpw_pkg::CNT_MAX);
    if (pwm) begin
      ev_d.m0 = wrap_pwm & ~stop;
    end else begin
      ev_d.m0 = cmp[0] | cap[0];
    end
    if (pwm_act) begin
      ev_d.m1 = (cnt_d == beff[1]);
    end else begin
      ev_d.m1 = cmp[1] | cap[1];
    end
  end

  // Interrupt pulses
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ev_q <= '0;
    end else begin
      ev_q <= ev_d;
    end
  end
  assign match0_irq_o   = ev_q.m0;
  assign match1_irq_o   = ev_q.m1;
  assign overflow_irq_o = ev_q.ovf;

  // Overflow flag, set beats clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ovf_q <= 1'b0;
    end else if (ev_d.ovf) begin
      ovf_q <= 1'b1;
    end else if (wsel(tpw_pkg::OFS_OPT0) & ~pwdata_i[tpw_pkg::OVF_POS]) begin
      ovf_q <= 1'b0;
    end
  end

  // Sticky status, read clears only the bits shown
  assign clr = (rd_acc && paddr_i == tpw_pkg::OFS_STAT) ? prdata_q[2:0]
                                                        : 3'h0;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev_d;
    end
  end
  assign irq_o = |(stat_q & mask_q);

  // Timer output pins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      out_q <= 2'h0;
    end else if (stop) begin
      out_q <= 2'h0;
    end else if (start_fr) begin
      out_q <= ~out_q;
    end else if (pwm_act) begin
      out_q[1] <= (cnt_d < beff[1]);
      out_q[0] <= out_q[0] ^ (wrap_pwm | start_pwm);
    end else if (fr) begin
      out_q <= out_q ^ cmp;
    end
  end
  assign timer_out_0_o = out_q[0];
  assign timer_out_1_o = out_q[1];

  // Read data latched in the setup phase
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0;
    end else if (rd_set) begin
      case (paddr_i)
        tpw_pkg::OFS_CTL0: prdata_q <= {24'h0, ce_q, 7'h0};
        tpw_pkg::OFS_CTL1: prdata_q <= {29'h0, mode_q};
        tpw_pkg::OFS_OPT0: prdata_q <= {26'h0, role_q, 3'h0, ovf_q};
        tpw_pkg::OFS_IOC:  prdata_q <= {28'h0, edge_q};
        tpw_pkg::OFS_CCR0: prdata_q <= {16'h0, ccr_q[0]};
        tpw_pkg::OFS_CCR1: prdata_q <= {16'h0, ccr_q[1]};
        tpw_pkg::OFS_CNT:  prdata_q <= {16'h0, cnt_q};
        tpw_pkg::OFS_STAT: prdata_q <= {29'h0, stat_q};
        tpw_pkg::OFS_MASK: prdata_q <= {29'h0, mask_q};
        default:           prdata_q <= 32'h0;
      endcase
    end
  end

  // Checks
  property p_pwm_enter;
    @(posedge mclk_i) disable iff (rst_i)
    start && mode_q == tpw_pkg::MODE_PWM && !stop |=> pwm;
  endproperty
  a_pwm_enter: assert property (p_pwm_enter)
    else $error("PWM state not entered");
  property p_pwm_period;
    @(posedge mclk_i) disable iff (rst_i)
    wrap_pwm && !stop |=> cnt_q == 16'h0000 && match0_irq_o;
  endproperty
  a_pwm_period: assert property (p_pwm_period)
    else $error("PWM period end wrong");
  property p_zero_duty;
    @(posedge mclk_i) disable iff (rst_i)
    pwm_act && beff[1] == 16'h0000 |=> !timer_out_1_o;
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("Output active at zero duty");
  property p_zero_irq;
    @(posedge mclk_i) disable iff (rst_i)
    pwm_act && beff[1] == 16'h0000 && cnt_d == 16'h0000
      |=> match1_irq_o && cnt_q == 16'h0000;
  endproperty
  a_zero_irq: assert property (p_zero_irq)
    else $error("No compare 1 interrupt at zero duty");
  property p_full_duty;
    @(posedge mclk_i) disable iff (rst_i)
    pwm_act && beff[0] != 16'hFFFF && beff[1] == beff[0] + 16'h0001
      |=> timer_out_1_o;
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("Output inactive at full duty");
  property p_pwm_irq_edge;
    @(posedge mclk_i) disable iff (rst_i)
    pwm && !stop && $past(pwm) && $fell(timer_out_1_o) |-> match1_irq_o;
  endproperty
  a_pwm_irq_edge: assert property (p_pwm_irq_edge)
    else $error("Compare 1 interrupt not with output edge");
  property p_fr_start;
    @(posedge mclk_i) disable iff (rst_i)
    start_fr |=> fr && {timer_out_1_o, timer_out_0_o} == ~$past(out_q);
  endproperty
  a_fr_start: assert property (p_fr_start)
    else $error("Outputs not inverted at start");
  property p_cmp_match;
    @(posedge mclk_i) disable iff (rst_i)
    cmp[1] && !stop |=> match1_irq_o
      && cnt_q == $past(ccr_q[1]) + 16'h0001
      && timer_out_1_o != $past(timer_out_1_o);
  endproperty
  a_cmp_match: assert property (p_cmp_match)
    else $error("Compare match late or missing");
  property p_overflow;
    @(posedge mclk_i) disable iff (rst_i)
    fr && !stop && cnt_q == 16'hFFFF
      |=> overflow_irq_o && ovf_q && cnt_q == 16'h0000 ##1 cnt_q == 16'h0001
          || $past(stop);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("Overflow handling wrong");
  property p_ovf_hold;
    @(posedge mclk_i) disable iff (rst_i)
    ovf_q && !(wr_en && paddr_i == tpw_pkg::OFS_OPT0
               && !pwdata_i[tpw_pkg::OVF_POS]) |=> ovf_q;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("Overflow flag lost");
  property p_capture;
    @(posedge mclk_i) disable iff (rst_i)
    cap[0] |=> ccr_q[0] == $past(cnt_q) && match0_irq_o;
  endproperty
  a_capture: assert property (p_capture)
    else $error("Capture value or interrupt wrong");
  property p_cnt_read;
    @(posedge mclk_i) disable iff (rst_i)
    rd_set && paddr_i == tpw_pkg::OFS_CNT |=> prdata_o[15:0] == $past(cnt_q);
  endproperty
  a_cnt_read: assert property (p_cnt_read)
    else $error("Counter read mismatch");
endmodule : tpw_timer
